/* hw/bos_regs.svh */
// Constants for the batch output sequencer: codes, bit positions, timing
`ifndef BOS_REGS_SVH
`define BOS_REGS_SVH

// ********************
// Clock and timing
// ********************
`define BOS_CLK_HZ          20000000
`define BOS_PULSE_MAX_HZ    4
// Least period of the pulse output, rounded up to whole cycles
`define BOS_PULSE_PERIOD_CYC \
	((`BOS_CLK_HZ + `BOS_PULSE_MAX_HZ - 1) / `BOS_PULSE_MAX_HZ)
`define BOS_PULSE_HALF_CYC  ((`BOS_PULSE_PERIOD_CYC + 1) / 2)
`define BOS_CYC_PER_S       `BOS_CLK_HZ
`define BOS_DELAY_MAX_S     3600

// ********************
// Restart modes
// ********************
`define BOS_RESTART_NORMAL  2'h0
`define BOS_RESTART_QUICK   2'h1
`define BOS_RESTART_AUTO    2'h2

// ********************
// Operator control source
// ********************
`define BOS_SRC_LOCAL       2'h0
`define BOS_SRC_REMOTE      2'h1
`define BOS_SRC_BOTH        2'h2

// ********************
// Switch output functions
// ********************
`define BOS_FN_UNUSED       3'h0
`define BOS_FN_CONTROL2     3'h1
`define BOS_FN_CONTROL3     3'h2
`define BOS_FN_FLOW_ALARM   3'h3
`define BOS_FN_RESET_STAT   3'h4
`define BOS_FN_BATCH_STAT   3'h5
`define BOS_FN_PULSE        3'h6

// ********************
// Pulse divider selections
// ********************
`define BOS_DIV_10          3'h0
`define BOS_DIV_100         3'h1
`define BOS_DIV_1000        3'h2
`define BOS_DIV_10000       3'h3
`define BOS_DIV_100000      3'h4

// ********************
// Operator menu item enable bit positions, switch output count, open code
// ********************
`define BOS_MENU_SIZING     0
`define BOS_MENU_SELECT     1
`define BOS_MENU_HISTORY    2
`define BOS_MENU_CONFIG     3
`define BOS_NUM_SW          5
`define BOS_CODE_OPEN       16'h0000

`endif

/* hw/bos_pkg.sv */
// Types shared by the batch output sequencer modules
package bos_pkg;

	// Operator and strap pins, all asynchronous to clk
	typedef struct packed {
		logic panel_start;
		logic panel_pause;
		logic panel_reset;
		logic remote_start;
		logic remote_pause;
		logic remote_reset;
		logic security_link;
		logic option_fitted;
	} bos_pins_t;

	// Settings of one delayed, pre-stopped control output
	typedef struct packed {
		logic [11:0] start_delay_s;
		logic [31:0] prestop_volume;
	} bos_valve_cfg_t;

	// Start, pause and reset commands after source selection
	typedef struct packed {
		logic start;
		logic pause;
		logic reset;
	} bos_cmd_t;

	// Batch sequencing states
	typedef enum logic [3:0] {
		BOS_READY   = 4'h1,
		BOS_RUNNING = 4'h2,
		BOS_PAUSED  = 4'h4,
		BOS_DONE    = 4'h8
	} bos_state_t;

	typedef logic [2:0] bos_func_t;

endpackage

/* hw/bos_delay_timer.sv */
// Whole-second delay timer: counts while run is high until target
`timescale 1ns/1ps
`include "bos_regs.svh"
module bos_delay_timer #(
	parameter int unsigned TICKS_PER_S = `BOS_CYC_PER_S
) (
	// Clock and control
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Timer control
	input  wire logic        clear,
	input  wire logic        run,
	input  wire logic [18:0] target_s,
	// Status
	output logic             done
);
	import bos_pkg::*;

	typedef struct packed {
		logic [24:0] pre;
		logic [18:0] secs;
	} bos_tmr_t;

	bos_tmr_t s_r;
	bos_tmr_t s_nxt;

	// Prescaler makes seconds; counting stops at the target
	always_comb begin
		s_nxt = s_r;
		if (clear) begin
			s_nxt = '0;
		end else if (run && (s_r.secs < target_s)) begin
			if (s_r.pre == 25'(TICKS_PER_S - 1)) begin
				s_nxt.pre  = '0;
				s_nxt.secs = s_r.secs + 19'h00001;
			end else begin
				s_nxt.pre = s_r.pre + 25'h0000001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// A zero target is met at once
	assign done = (s_r.secs >= target_s);

endmodule

/* hw/bos_pulse_out.sv */
// Divided volume pulse output, paced to the least pulse period
`timescale 1ns/1ps
`include "bos_regs.svh"
module bos_pulse_out #(
	parameter int unsigned HALF_CYC = `BOS_PULSE_HALF_CYC
) (
	// Clock and control
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// Volume counts and divider
	input  wire logic       tick,
	input  wire logic [2:0] div_sel,
	// Pulse
	output logic            pulse
);
	import bos_pkg::*;

	typedef struct packed {
		logic [16:0] div;
		logic [15:0] owed;
		logic [22:0] phase;
		logic        pulse;
	} bos_pls_t;

	bos_pls_t s_r;
	bos_pls_t s_nxt;
	logic     inc;
	logic     dec;

	// Display counts per output pulse
	function automatic logic [16:0] factor(input logic [2:0] sel);
		unique case (sel)
			`BOS_DIV_100:    factor = 17'd100;
			`BOS_DIV_1000:   factor = 17'd1000;
			`BOS_DIV_10000:  factor = 17'd10000;
			`BOS_DIV_100000: factor = 17'd100000;
			default:         factor = 17'd10;
		endcase
	endfunction

	// Owed pulses queue up to 65535, so a burst of flow within that is not lost, only paced
	always_comb begin
		s_nxt = s_r;
		inc   = 1'b0;
		dec   = 1'b0;
		if (tick) begin
			if (s_r.div >= factor(div_sel) - 17'h00001) begin
				s_nxt.div = '0;
				inc       = (s_r.owed != 16'hffff);
			end else begin
				s_nxt.div = s_r.div + 17'h00001;
			end
		end
		if (s_r.phase != 23'h000000) begin
			s_nxt.phase = s_r.phase - 23'h000001;
		end else if (s_r.pulse) begin
			s_nxt.pulse = 1'b0;
			s_nxt.phase = 23'(HALF_CYC - 1);
		end else if (s_r.owed != 16'h0000) begin
			s_nxt.pulse = 1'b1;
			s_nxt.phase = 23'(HALF_CYC - 1);
			dec         = 1'b1;
		end
		s_nxt.owed = s_r.owed + 16'(inc) - 16'(dec);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign pulse = s_r.pulse;

endmodule

/* hw/bos_top.sv */
// Batch output sequencer: control outputs, restart, switch outputs
//
// Overview of operation
// - Control 1 on at start, off when batched volume reaches setpoint.
// - Control 2 turns on after its start delay from Control 1 on.
// - Control 2 turns off its pre-stop volume before Control 1 does.
// - Control 3 behaves like Control 2 with its own delay and stop.
// - Normal restart holds result; start refused until reset gives ready.
// - Quick restart: one start after batch end resets and starts again.
// - Auto restart: after restart delay, reset and start without operator.
// - Auto restart stops once the configured batch cycle count is done.
// - Each switch output is unused or one of six functions.
// - Several switch outputs may carry the same function identically.
// - Outputs three to five work only with the fitted option.
// - Pulse function emits pulses proportional to dispensed volume.
// - Pulse rate divides by one of five factors, 10 to 100000.
// - Pulse output never exceeds 4 Hz.
// - Grand total of product; cleared only after request and confirm.
// - Defaults restored only after request and a separate confirm.
// - Config and operator menus each have a code; 0000 disables it.
// - Config entry also needs the external security link present.
// - Operator menu offers only the individually enabled items.
// - Selectable on/off for the 16-point input lineariser.
// - Commands come from panel, remote switches, or both, as set.
// - Config entry is refused while a batch is running.
// - Control 2 and 3 start delays range from 0 to 3600 s.
// - Batch status is inverse of Control 1 but stays open on pause.
// - Reset status shows batch started versus reset and ready.
`timescale 1ns/1ps
`include "bos_regs.svh"
module bos_top #(
	parameter int unsigned TICKS_PER_S = `BOS_CYC_PER_S,
	parameter int unsigned PULSE_HALF  = `BOS_PULSE_HALF_CYC
) (
	// Clock, reset, enable
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   ce,
	// Operator and strap pins
	input  wire bos_pkg::bos_pins_t     pins,
	// Measurement, one display count per tick
	input  wire logic                   count_tick,
	input  wire logic                   flow_alarm_in,
	// Batch configuration
	input  wire logic [31:0]            batch_setpoint,
	input  wire bos_pkg::bos_valve_cfg_t valve2_cfg,
	input  wire bos_pkg::bos_valve_cfg_t valve3_cfg,
	input  wire logic [1:0]             restart_mode,
	input  wire logic [18:0]            restart_delay_s,
	input  wire logic [7:0]             batch_cycles,
	// System configuration
	input  wire bos_pkg::bos_func_t [4:0] out_func,
	input  wire logic [2:0]             pulse_div_sel,
	input  wire logic [1:0]             control_source,
	input  wire logic [15:0]            cfg_code,
	input  wire logic [15:0]            op_code,
	input  wire logic [3:0]             menu_enable,
	input  wire logic                   lineariser_sel,
	// Menu requests, one-cycle pulses
	input  wire logic                   cfg_entry_req,
	input  wire logic                   op_entry_req,
	input  wire logic [15:0]            code_entry,
	input  wire logic                   menu_exit,
	input  wire logic                   gt_clear_req,
	input  wire logic                   defaults_req,
	input  wire logic                   confirm,
	input  wire logic                   cancel,
	// Loads
	output logic                        control1,
	output logic [4:0]                  sw_out,
	// Status
	output logic [31:0]                 batched_volume,
	output logic [39:0]                 grand_total,
	output logic [7:0]                  batch_count,
	output logic [3:0]                  batch_state,
	output logic                        cfg_open,
	output logic                        op_open,
	output logic [3:0]                  op_items,
	output logic                        lineariser_en,
	output logic                        defaults_load
);
	import bos_pkg::*;

	// ********************
	// State
	// ********************
	typedef struct packed {
		bos_pins_t   sync1;
		bos_pins_t   sync2;
		bos_pins_t   prev;
		bos_state_t  st;
		logic [31:0] vol;
		logic [39:0] total;
		logic [7:0]  cycles;
		logic        gt_armed;
		logic        df_armed;
		logic        defaults;
		logic        cfg_open;
		logic        op_open;
		logic        lin_en;
		logic        ctl1;
		logic [4:0]  sw;
		logic [3:0]  items;
	} bos_top_t;

	bos_top_t  s_r;
	bos_top_t  s_nxt;
	bos_cmd_t  cmd;
	logic      go;
	logic      enter_done;
	logic      v2_done;
	logic      v3_done;
	logic      rs_done;
	logic      pulse;
	logic      ctl2;
	logic      ctl3;
	logic      rst_stat;
	logic      bat_stat;
	logic [31:0] vol_inc;
	logic [7:0]  cyc_lim;

	// True once the volume is within the pre-stop volume of the setpoint
	function automatic logic past_stop(input logic [31:0] vol,
		input logic [31:0] setp, input logic [31:0] pre);
		past_stop = ({1'b0, vol} + {1'b0, pre}) >= {1'b0, setp};
	endfunction

	// An all-zero stored code leaves the menu open
	function automatic logic code_ok(input logic [15:0] stored,
		input logic [15:0] given);
		code_ok = (stored == `BOS_CODE_OPEN) || (stored == given);
	endfunction

	// Delay target clipped to the settable range of start delays
	function automatic logic [18:0] clip_delay(input logic [11:0] d);
		clip_delay = (d > 12'(`BOS_DELAY_MAX_S)) ?
			19'(`BOS_DELAY_MAX_S) : {7'h00, d};
	endfunction

	// ********************
	// Timers and pulse generator
	// ********************
	bos_delay_timer #(.TICKS_PER_S(TICKS_PER_S)) u_v2_delay (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.clear    (go),
		.run      (s_r.st == BOS_RUNNING),
		.target_s (clip_delay(valve2_cfg.start_delay_s)),
		.done     (v2_done)
	);

	bos_delay_timer #(.TICKS_PER_S(TICKS_PER_S)) u_v3_delay (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.clear    (go),
		.run      (s_r.st == BOS_RUNNING),
		.target_s (clip_delay(valve3_cfg.start_delay_s)),
		.done     (v3_done)
	);

	bos_delay_timer #(.TICKS_PER_S(TICKS_PER_S)) u_restart (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.clear    (enter_done),
		.run      ((s_r.st == BOS_DONE) &&
			(restart_mode == `BOS_RESTART_AUTO)),
		.target_s (restart_delay_s),
		.done     (rs_done)
	);

	// Pulse counts follow every display count, batching or not
	bos_pulse_out #(.HALF_CYC(PULSE_HALF)) u_pulse (
		.clk     (clk),
		.rst     (rst),
		.ce      (ce),
		.tick    (count_tick),
		.div_sel (pulse_div_sel),
		.pulse   (pulse)
	);

	// ********************
	// Command selection and batch sequencing
	// ********************
	// Edges of synchronised buttons, gated by the control source
	always_comb begin
		logic loc;
		logic rem;
		loc = (control_source != `BOS_SRC_REMOTE);
		rem = (control_source != `BOS_SRC_LOCAL);
		cmd.start = (loc && s_r.sync2.panel_start &&
			!s_r.prev.panel_start) ||
			(rem && s_r.sync2.remote_start && !s_r.prev.remote_start);
		cmd.pause = (loc && s_r.sync2.panel_pause &&
			!s_r.prev.panel_pause) ||
			(rem && s_r.sync2.remote_pause && !s_r.prev.remote_pause);
		cmd.reset = (loc && s_r.sync2.panel_reset &&
			!s_r.prev.panel_reset) ||
			(rem && s_r.sync2.remote_reset && !s_r.prev.remote_reset);
	end

	// Zero cycles would never stop, so it is taken as one
	assign cyc_lim = (batch_cycles == 8'h00) ? 8'h01 : batch_cycles;
	assign vol_inc = s_r.vol + 32'(count_tick);

	// Start of a fresh batch, from ready or as a restart
	always_comb begin
		go = 1'b0;
		unique case (s_r.st)
			BOS_READY: go = cmd.start;
			BOS_DONE: begin
				if (restart_mode == `BOS_RESTART_QUICK) begin
					go = cmd.start;
				end else if (restart_mode == `BOS_RESTART_AUTO) begin
					go = rs_done && (s_r.cycles < cyc_lim);
				end
			end
			default: go = 1'b0;
		endcase
	end

	// Batch completes when the running volume reaches the setpoint
	assign enter_done = (s_r.st == BOS_RUNNING) &&
		(vol_inc >= batch_setpoint);

	// Selectable functions; Control 2 and 3 need Control 1 energised
	assign ctl2 = (s_r.st == BOS_RUNNING) && v2_done &&
		!past_stop(s_r.vol, batch_setpoint, valve2_cfg.prestop_volume);
	assign ctl3 = (s_r.st == BOS_RUNNING) && v3_done &&
		!past_stop(s_r.vol, batch_setpoint, valve3_cfg.prestop_volume);
	assign rst_stat = (s_r.st == BOS_READY);
	assign bat_stat = (s_r.st == BOS_READY) || (s_r.st == BOS_DONE);

	// ********************
	// Next state
	// ********************
	always_comb begin
		s_nxt = s_r;
		s_nxt.sync1 = pins;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev  = s_r.sync2;
		s_nxt.lin_en = lineariser_sel;

		// Grand total counts every display count; a count that
		// arrives with the confirm is kept
		s_nxt.total = s_r.total + 40'(count_tick);
		if (s_r.gt_armed && confirm) begin
			s_nxt.total = 40'(count_tick);
		end

		// Two-step confirm for clearing and restoring defaults
		if (gt_clear_req) begin
			s_nxt.gt_armed = 1'b1;
			s_nxt.df_armed = 1'b0;
		end else if (defaults_req) begin
			s_nxt.df_armed = 1'b1;
			s_nxt.gt_armed = 1'b0;
		end else if (confirm || cancel) begin
			s_nxt.gt_armed = 1'b0;
			s_nxt.df_armed = 1'b0;
		end
		s_nxt.defaults = s_r.df_armed && confirm &&
			!gt_clear_req && !defaults_req;

		// Batch sequencing
		if (go) begin
			s_nxt.st  = BOS_RUNNING;
			s_nxt.vol = 32'(count_tick);
			s_nxt.cycles = (s_r.st == BOS_READY) ? 8'h01 :
				s_r.cycles + 8'h01;
			if (32'(count_tick) >= batch_setpoint) begin
				s_nxt.st = BOS_DONE;
			end
		end else begin
			unique case (s_r.st)
				BOS_READY: begin
					s_nxt.vol = s_r.vol;
				end
				BOS_RUNNING: begin
					s_nxt.vol = vol_inc;
					if (enter_done) begin
						s_nxt.st = BOS_DONE;
					end else if (cmd.pause) begin
						s_nxt.st = BOS_PAUSED;
					end
				end
				BOS_PAUSED: begin
					if (cmd.start) begin
						s_nxt.st = BOS_RUNNING;
					end else if (cmd.reset) begin
						s_nxt.st  = BOS_READY;
						s_nxt.vol = '0;
					end
				end
				BOS_DONE: begin
					if (cmd.reset) begin
						s_nxt.st  = BOS_READY;
						s_nxt.vol = '0;
					end
				end
			endcase
		end

		// Menu access
		if (menu_exit) begin
			s_nxt.cfg_open = 1'b0;
			s_nxt.op_open  = 1'b0;
		end else if (cfg_entry_req) begin
			s_nxt.cfg_open = code_ok(cfg_code, code_entry) &&
				s_r.sync2.security_link &&
				(s_r.st != BOS_RUNNING) && (s_r.st != BOS_PAUSED);
		end else if (op_entry_req) begin
			s_nxt.op_open = code_ok(op_code, code_entry);
		end
		if ((s_r.st == BOS_RUNNING) || (s_r.st == BOS_PAUSED)) begin
			s_nxt.cfg_open = 1'b0;
		end
		// Offered items are registered so the output is a flip-flop
		s_nxt.items = s_nxt.op_open ? menu_enable : 4'h0;

		// Control output and switch output routing
		s_nxt.ctl1 = (s_nxt.st == BOS_RUNNING);
		for (int i = 0; i < `BOS_NUM_SW; i++) begin
			unique case (out_func[i])
				`BOS_FN_CONTROL2:   s_nxt.sw[i] = ctl2;
				`BOS_FN_CONTROL3:   s_nxt.sw[i] = ctl3;
				`BOS_FN_FLOW_ALARM: s_nxt.sw[i] = flow_alarm_in;
				`BOS_FN_RESET_STAT: s_nxt.sw[i] = rst_stat;
				`BOS_FN_BATCH_STAT: s_nxt.sw[i] = bat_stat;
				`BOS_FN_PULSE:      s_nxt.sw[i] = pulse;
				default:            s_nxt.sw[i] = 1'b0;
			endcase
			if ((i >= 2) && !s_r.sync2.option_fitted) begin
				s_nxt.sw[i] = 1'b0;
			end
		end
	end

	// ********************
	// Registers
	// ********************
	always_ff @(posedge clk) begin
		if (rst) begin
			s_r    <= '0;
			s_r.st <= BOS_READY;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// Outputs, all straight from the state register
	assign control1       = s_r.ctl1;
	assign sw_out         = s_r.sw;
	assign batched_volume = s_r.vol;
	assign grand_total    = s_r.total;
	assign batch_count    = s_r.cycles;
	assign batch_state    = s_r.st;
	assign cfg_open       = s_r.cfg_open;
	assign op_open        = s_r.op_open;
	assign op_items       = s_r.items;
	assign lineariser_en  = s_r.lin_en;
	assign defaults_load  = s_r.defaults;

endmodule

/* verif/bos_top_props.sv */
// Port assertions for the batch output sequencer
`timescale 1ns/1ps
module bos_top_props #(
	parameter int unsigned TICKS_PER_S = 20,
	parameter int unsigned PULSE_HALF  = 4
) (
	// Clock and reset
	input wire logic                     clk,
	input wire logic                     rst,
	// Inputs
	input wire bos_pkg::bos_pins_t       pins,
	input wire logic [31:0]              batch_setpoint,
	input wire bos_pkg::bos_func_t [4:0] out_func,
	input wire logic                     confirm,
	// Outputs
	input wire logic                     control1,
	input wire logic [4:0]               sw_out,
	input wire logic [31:0]              batched_volume,
	input wire logic [39:0]              grand_total,
	input wire logic [3:0]               batch_state,
	input wire logic                     cfg_open,
	input wire logic                     defaults_load
);
	import bos_pkg::*;
	logic [31:0] gap_r;
	// Cycles since last pulse rise; saturated while another function is set
	always_ff @(posedge clk) begin
		if (rst || out_func[0] != 3'h6)
			gap_r <= 32'hffffffff;
		else if ($rose(sw_out[0]))
			gap_r <= 32'h1;
		else if (gap_r != 32'hffffffff)
			gap_r <= gap_r + 32'h1;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_ctl1_running: assert property (
		control1 == (batch_state == 4'h2))
		else $error("control1 differs from running state");
	a_ctl1_stop: assert property (
		$fell(control1) && batch_state == 4'h8 |->
		batched_volume >= batch_setpoint)
		else $error("batch ended short of setpoint");
	a_reset_stat: assert property (
		out_func[0] == 3'h4 && $stable(out_func[0]) && !$past(rst) |->
		sw_out[0] == ($past(batch_state) == 4'h1))
		else $error("reset status wrong");
	a_batch_stat: assert property (
		out_func[1] == 3'h5 && $stable(out_func[1]) && !$past(rst) |->
		sw_out[1] == ($past(batch_state) == 4'h1 ||
		$past(batch_state) == 4'h8))
		else $error("batch status wrong");
	a_option_gate: assert property (
		(!pins.option_fitted) [*4] |-> sw_out[4:2] == 3'h0)
		else $error("optional output active without option");
	a_cfg_refuse: assert property (
		$past(batch_state) == 4'h2 |-> !cfg_open)
		else $error("configuration open while running");
	a_pulse_gap: assert property (
		$rose(sw_out[0]) && out_func[0] == 3'h6 |->
		gap_r >= 2 * PULSE_HALF)
		else $error("pulse output too fast");
	a_total_clear: assert property (
		grand_total < $past(grand_total) && !$past(rst) |-> $past(confirm))
		else $error("grand total dropped without confirm");
	a_dflt_confirm: assert property (
		defaults_load |-> $past(confirm))
		else $error("defaults loaded without confirm");
endmodule
bind bos_top bos_top_props #(.TICKS_PER_S(TICKS_PER_S),
	.PULSE_HALF(PULSE_HALF)) u_props (.clk, .rst, .pins, .batch_setpoint,
	.out_func, .confirm, .control1, .sw_out, .batched_volume, .grand_total,
	.batch_state, .cfg_open, .defaults_load);

/* verif/bos_flow_src.sv */
// Flowmeter model: a burst of display counts at a chosen spacing
`timescale 1ns/1ps
module bos_flow_src (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Burst request
	input  wire logic        go,
	input  wire logic [15:0] n,
	input  wire logic [7:0]  gap,
	// Counts
	output logic             count_tick,
	output logic             busy
);
	logic [15:0] left_r;
	logic [7:0]  wait_r;
	// Go is only honoured while idle, so a burst is never cut short
	always_ff @(posedge clk) begin
		count_tick <= 1'b0;
		if (rst) begin
			left_r <= 16'h0;
			wait_r <= 8'h0;
		end else if (left_r == 16'h0) begin
			left_r <= go ? n : 16'h0;
			wait_r <= 8'h0;
		end else if (wait_r != 8'h0) begin
			wait_r <= wait_r - 8'h1;
		end else begin
			count_tick <= 1'b1;
			left_r <= left_r - 16'h1;
			wait_r <= gap;
		end
	end
	assign busy = (left_r != 16'h0);
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the batch output sequencer
`timescale 1ns/1ps
`include "bos_regs.svh"
module tb_top;
	import bos_pkg::*;
	localparam bos_pins_t P_START = 8'h80;
	localparam bos_pins_t P_PAUSE = 8'h40;
	localparam bos_pins_t P_RESET = 8'h20;
	localparam bos_pins_t R_START = 8'h10;
	// ****************
	// Signals
	// ****************
	logic clk = 0, rst = 1, ce = 1, flow_alarm_in = 0, lineariser_sel = 0;
	bos_pins_t pins = 8'h0;
	logic [31:0] batch_setpoint = 32'h0, batched_volume, v_off;
	bos_valve_cfg_t valve2_cfg = 44'h0, valve3_cfg = 44'h0;
	logic [1:0] restart_mode = 2'h0, control_source = 2'h2;
	logic [18:0] restart_delay_s = 19'h0;
	logic [7:0] batch_cycles = 8'h1, fg = 8'h0, batch_count;
	bos_func_t [4:0] out_func = 15'h0;
	logic [2:0] pulse_div_sel = 3'h0;
	logic [15:0] cfg_code = 16'h0, op_code = 16'h0, code_entry = 16'h0;
	logic [15:0] fn = 16'h0;
	logic [3:0] menu_enable = 4'hf, batch_state, op_items;
	logic cfg_entry_req = 0, op_entry_req = 0, menu_exit = 0, cancel = 0;
	logic gt_clear_req = 0, defaults_req = 0, confirm = 0, go = 0;
	logic count_tick, control1, cfg_open, op_open, lineariser_en, busy;
	logic defaults_load, c1_q = 0;
	logic [4:0] sw_out, sw_q = 5'h0;
	logic [39:0] grand_total;
	int fail_count = 0, num_checks = 0, cyc = 0, t_c1, t_s0, t_s1;
	int rises = 0, dif = 0;
	bos_top #(.TICKS_PER_S(20), .PULSE_HALF(4)) u_dut (.clk, .rst, .ce,
		.pins, .count_tick, .flow_alarm_in, .batch_setpoint, .valve2_cfg,
		.valve3_cfg, .restart_mode, .restart_delay_s, .batch_cycles,
		.out_func, .pulse_div_sel, .control_source, .cfg_code, .op_code,
		.menu_enable, .lineariser_sel, .cfg_entry_req, .op_entry_req,
		.code_entry, .menu_exit, .gt_clear_req, .defaults_req, .confirm,
		.cancel, .control1, .sw_out, .batched_volume, .grand_total,
		.batch_count, .batch_state, .cfg_open, .op_open, .op_items,
		.lineariser_en, .defaults_load);
	bos_flow_src u_flow (.clk, .rst, .go, .n(fn), .gap(fg), .count_tick,
		.busy);
	always #25 clk = ~clk;
	// Edge timing monitor; the ceiling cuts a hang short
	always @(posedge clk) begin
		cyc++;
		if (control1 && !c1_q)
			t_c1 = cyc;
		if (sw_out[0] && !sw_q[0]) begin
			t_s0 = cyc;
			rises++;
		end
		if (sw_out[1] && !sw_q[1])
			t_s1 = cyc;
		if (!sw_out[0] && sw_q[0])
			v_off = batched_volume;
		if (out_func[2] == out_func[0] && sw_out[2] !== sw_out[0])
			dif++;
		c1_q = control1;
		sw_q = sw_out;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	// ****************
	// Helpers
	// ****************
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Button held past the synchroniser delay
	task automatic press(input bos_pins_t m);
		@(posedge clk);
		pins <= pins | m;
		repeat (4) @(posedge clk);
		pins <= pins & ~m;
		repeat (4) @(posedge clk);
		#1;
	endtask
	// One-cycle menu strobe: 0 cfg,1 op,2 exit,3 clear,4 dflt,5 ok,6 cancel
	task automatic ctl(input int k, input logic [15:0] code);
		@(posedge clk);
		code_entry <= code;
		{cfg_entry_req, op_entry_req, menu_exit, gt_clear_req, defaults_req,
			confirm, cancel} <= 7'h40 >> k;
		@(posedge clk);
		{cfg_entry_req, op_entry_req, menu_exit, gt_clear_req, defaults_req,
			confirm, cancel} <= 7'h0;
		#1;
	endtask
	task automatic flow(input logic [15:0] n, input logic [7:0] g);
		@(posedge clk);
		fn <= n;
		fg <= g;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		#1;
		while (busy) begin
			@(posedge clk);
			#1;
		end
	endtask
	task automatic wait_st(input logic [3:0] s);
		for (int i = 0; i < 3000 && batch_state !== s; i++) begin
			@(posedge clk);
			#1;
		end
		chk(batch_state, s);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_menu();
		@(posedge clk);
		cfg_code <= 16'h1234;
		menu_enable <= 4'h5;
		lineariser_sel <= 1'b1;
		flow_alarm_in <= 1'b1;
		out_func <= {9'h0, `BOS_FN_FLOW_ALARM, 3'h0};
		ctl(0, 16'h1234);
		chk(cfg_open, 0);
		pins <= pins | 8'h03;
		repeat (4) @(posedge clk);
		ctl(0, 16'h1111);
		chk(cfg_open, 0);
		ctl(0, 16'h1234);
		chk(cfg_open, 1);
		chk(lineariser_en, 1);
		chk(sw_out[1], 1);
		ctl(2, 16'h0);
		ctl(1, 16'h9999);
		chk(op_items, 4'h5);
		chk(op_open, 1);
		ctl(2, 16'h0);
		cfg_code <= 16'h0;
		ctl(0, 16'h4321);
		chk(cfg_open, 1);
		ctl(2, 16'h0);
		$display("t_menu done");
	endtask
	task automatic t_normal();
		batch_setpoint <= 32'ha;
		valve2_cfg <= {12'h0, 32'h3};
		valve3_cfg <= {12'h2, 32'h0};
		out_func <= {6'h0, `BOS_FN_CONTROL2, `BOS_FN_CONTROL3,
			`BOS_FN_CONTROL2};
		press(P_START);
		flow(16'ha, 8'h14);
		wait_st(4'h8);
		chk(batched_volume, 40'ha);
		chk(v_off, 40'h7);
		chk(40'(t_s0 - t_c1), 40'h1);
		chk(40'(t_s1 - t_c1 >= 40 && t_s1 - t_c1 <= 43), 40'h1);
		chk(40'(dif), 40'h0);
		press(P_START);
		chk(batch_state, 4'h8);
		press(P_RESET);
		wait_st(4'h1);
		chk(batched_volume, 40'h0);
		$display("t_normal done");
	endtask
	task automatic t_quick();
		restart_mode <= `BOS_RESTART_QUICK;
		control_source <= `BOS_SRC_REMOTE;
		batch_setpoint <= 32'h3;
		out_func <= {9'h0, `BOS_FN_BATCH_STAT, `BOS_FN_RESET_STAT};
		press(P_START);
		chk(batch_state, 4'h1);
		press(R_START);
		wait_st(4'h2);
		flow(16'h3, 8'h2);
		wait_st(4'h8);
		press(R_START);
		wait_st(4'h2);
		chk(batched_volume, 40'h0);
		flow(16'h3, 8'h2);
		wait_st(4'h8);
		restart_mode <= `BOS_RESTART_NORMAL;
		control_source <= `BOS_SRC_BOTH;
		press(P_RESET);
		wait_st(4'h1);
		$display("t_quick done");
	endtask
	task automatic t_auto();
		restart_mode <= `BOS_RESTART_AUTO;
		restart_delay_s <= 19'h1;
		batch_cycles <= 8'h2;
		batch_setpoint <= 32'h2;
		press(P_START);
		flow(16'h2, 8'h2);
		wait_st(4'h8);
		wait_st(4'h2);
		flow(16'h2, 8'h2);
		wait_st(4'h8);
		repeat (100) @(posedge clk);
		#1;
		chk(batch_state, 4'h8);
		chk(batch_count, 40'h2);
		restart_mode <= `BOS_RESTART_NORMAL;
		press(P_RESET);
		wait_st(4'h1);
		$display("t_auto done");
	endtask
	task automatic t_pulse();
		batch_setpoint <= 32'hffff;
		out_func <= {12'h0, `BOS_FN_PULSE};
		press(P_START);
		for (int d = 0; d < 2; d++) begin
			pulse_div_sel <= 3'(d);
			repeat (3) @(posedge clk);
			rises = 0;
			flow(d ? 16'hc8 : 16'h14, 8'h0);
			repeat (50) @(posedge clk);
			chk(40'(rises), 40'h2);
		end
		press(P_PAUSE);
		press(P_RESET);
		wait_st(4'h1);
		$display("t_pulse done");
	endtask
	task automatic t_total();
		logic [39:0] g;
		g = grand_total;
		ctl(3, 16'h0);
		ctl(6, 16'h0);
		ctl(5, 16'h0);
		chk(grand_total, g);
		ctl(3, 16'h0);
		ctl(5, 16'h0);
		chk(grand_total, 40'h0);
		ctl(4, 16'h0);
		chk(defaults_load, 0);
		ctl(5, 16'h0);
		chk(defaults_load, 1);
		$display("t_total done");
	endtask
	// Reset, then the scenarios in order
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_menu();
		t_normal();
		t_quick();
		t_auto();
		t_pulse();
		t_total();
		tally_and_finish();
	end
endmodule
